// [common/tmr16_cfg.svh]
`ifndef TMR16_CFG_SVH
`define TMR16_CFG_SVH

// register byte addresses
`define TMR16_A_CTRL_A    8'h00
`define TMR16_A_CTRL_B    8'h01
`define TMR16_A_CNT_L     8'h02
`define TMR16_A_CNT_H     8'h03
`define TMR16_A_CMPA_L    8'h04
`define TMR16_A_CMPA_H    8'h05
`define TMR16_A_CMPB_L    8'h06
`define TMR16_A_CMPB_H    8'h07
`define TMR16_A_CAP_L     8'h08
`define TMR16_A_CAP_H     8'h09
`define TMR16_A_FLAG      8'h0A
`define TMR16_A_MASK      8'h0B
`define TMR16_A_ACK       8'h0C

// flag and mask bit positions
`define TMR16_B_OVF       0
`define TMR16_B_CMPA      1
`define TMR16_B_CMPB      2
`define TMR16_B_CAP       3

// control b fields
`define TMR16_CB_CS_LSB   0
`define TMR16_CB_WGM_LSB  3
`define TMR16_CB_EDGE     6
`define TMR16_CB_NCANCEL  7

// fixed values
`define TMR16_BOTTOM      16'h0000
`define TMR16_MAX         16'hFFFF
`define TMR16_TOP_8       16'h00FF
`define TMR16_TOP_9       16'h01FF
`define TMR16_TOP_10      16'h03FF
`define TMR16_NC_LEN      4
`define TMR16_RST_BYTE    8'h00

`endif

// [common/tmr16_pkg.sv]
package tmr16_pkg;

  typedef enum logic [2:0] {
    TMR16_SRC_STOP = 3'h0, TMR16_SRC_DIV1 = 3'h1, TMR16_SRC_DIV8 = 3'h2,
    TMR16_SRC_DIV64 = 3'h3, TMR16_SRC_DIV256 = 3'h4, TMR16_SRC_DIV1024 = 3'h5,
    TMR16_SRC_EXTF = 3'h6, TMR16_SRC_EXTR = 3'h7
  } tmr16_src_t;

  typedef enum logic [2:0] {
    TMR16_TOP_MAX = 3'h0, TMR16_TOP_F8 = 3'h1, TMR16_TOP_F9 = 3'h2,
    TMR16_TOP_F10 = 3'h3, TMR16_TOP_CMPA = 3'h4, TMR16_TOP_CAP = 3'h5
  } tmr16_topsel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr16_bus_t;

  typedef struct packed {
    logic cap;
    logic cmpb;
    logic cmpa;
    logic ovf;
  } tmr16_flags_t;

endpackage

// [rtl/tmr16_tick.sv]
`timescale 1ns/1ps
`include "tmr16_cfg.svh"

module tmr16_tick (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // control
  input  wire tmr16_pkg::tmr16_src_t src,
  input  wire logic                 ext_clock_pin,
  // tick
  output logic                      timer_tick
);

  logic [9:0] pre_ff;
  logic       ext_ff;
  logic       ext_rise;
  logic       ext_fall;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 10'h000;
    end else begin
      pre_ff <= pre_ff + 10'h001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_ff <= 1'b0;
    end else begin
      ext_ff <= ext_clock_pin;
    end
  end

  assign ext_rise = ext_clock_pin & ~ext_ff;
  assign ext_fall = ~ext_clock_pin & ext_ff;

  always_comb begin
    case (src)
      tmr16_pkg::TMR16_SRC_DIV1:    timer_tick = 1'b1;
      tmr16_pkg::TMR16_SRC_DIV8:    timer_tick = (pre_ff[2:0] == 3'h7);
      tmr16_pkg::TMR16_SRC_DIV64:   timer_tick = (pre_ff[5:0] == 6'h3F);
      tmr16_pkg::TMR16_SRC_DIV256:  timer_tick = (pre_ff[7:0] == 8'hFF);
      tmr16_pkg::TMR16_SRC_DIV1024: timer_tick = (pre_ff == 10'h3FF);
      tmr16_pkg::TMR16_SRC_EXTF:    timer_tick = ext_fall;
      tmr16_pkg::TMR16_SRC_EXTR:    timer_tick = ext_rise;
      default:                      timer_tick = 1'b0;
    endcase
  end

endmodule

// [rtl/tmr16_capin.sv]
`timescale 1ns/1ps
`include "tmr16_cfg.svh"

module tmr16_capin #(
  parameter int NC_LEN = `TMR16_NC_LEN
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // control
  input  wire logic sel_comp,
  input  wire logic noise_cancel,
  input  wire logic rise_edge,
  // sources
  input  wire logic capture_pin,
  input  wire logic comparator_output,
  // event
  output logic      cap_event
);

  logic [NC_LEN-1:0] hist_ff;
  logic              filt_ff;
  logic              prev_ff;
  logic              raw;
  logic              lvl;

  assign raw = sel_comp ? comparator_output : capture_pin;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hist_ff <= '0;
    end else begin
      hist_ff <= {hist_ff[NC_LEN-2:0], raw};
    end
  end

  // filtered level changes only after NC_LEN equal samples
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filt_ff <= 1'b0;
    end else if (&hist_ff) begin
      filt_ff <= 1'b1; // R11
    end else if (~|hist_ff) begin
      filt_ff <= 1'b0; // R11
    end
  end

  assign lvl = noise_cancel ? filt_ff : hist_ff[0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= lvl;
    end
  end

  assign cap_event = rise_edge ? (lvl & ~prev_ff) : (~lvl & prev_ff); // R10

endmodule

// [rtl/tmr16_top.sv]
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`include "tmr16_cfg.svh"

// Notes on behaviour
// R1: four 16-bit registers share one high holder
// R2: low-byte write loads whole register at once
// R3: counter or capture low-byte read copies high byte to holder
// R4: compare reads return bytes directly, holder untouched
// R5: cpu writes high first, reads low first
// R6: control registers accessed directly as bytes
// R7: counter advances on selected tick, else stops
// R8: compares run always; match sets flag
// R9: compare results drive both wave outputs
// R10: selected edge stores counter into capture; code skips the store while capture is top
// R11: capture path has noise filter
// R12: top is fixed, compare-a or capture
// R13: compare-a as top buffered, no pwm
// R14: capture as top frees compare-a pwm
// R15: zero is bottom, all ones is max
// R16: four flags, each individually masked
// R17: cpu counter write beats clear or count
// R18: capture flag set with capture copy; code still sets the flag when a cpu capture low write beats the copy
// R19: flags clear by vector ack or write-one
module tmr16_top (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // pins
  input  wire logic       ext_clock_pin,
  input  wire logic       capture_pin,
  input  wire logic       comparator_output,
  output logic            wave_out_a,
  output logic            wave_out_b,
  // interrupt
  output logic            irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]  rsync_ff;
  logic        rst_n;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsync_ff <= 2'b00;
    end else begin
      rsync_ff <= {rsync_ff[0], 1'b1};
    end
  end

  assign rst_n = rsync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  tmr16_pkg::tmr16_bus_t   bus;
  tmr16_pkg::tmr16_flags_t flag_ff;
  tmr16_pkg::tmr16_flags_t mask_ff;
  tmr16_pkg::tmr16_flags_t set_ev;
  tmr16_pkg::tmr16_flags_t clr_wr;
  tmr16_pkg::tmr16_src_t   src;
  tmr16_pkg::tmr16_topsel_t topsel;
  logic [7:0]  timer_control_a_ff;
  logic [7:0]  timer_control_b_ff;
  logic [7:0]  hold_ff;
  logic [15:0] count_value_ff;
  logic [15:0] compare_a_value_ff;
  logic [15:0] compare_b_value_ff;
  logic [15:0] cmpa_buf_ff;
  logic [15:0] cmpb_buf_ff;
  logic [15:0] capture_value_ff;
  logic [15:0] top_val;
  logic [15:0] nxt_count;
  logic [7:0]  nxt_rdata;
  logic        timer_tick;
  logic        cap_event;
  logic        at_top;
  logic        at_bottom;
  logic        match_a;
  logic        match_b;
  logic        pwm_mode;
  logic        up_ff;
  logic        cnt_wr;
  logic        wave_a_ff;
  logic        wave_b_ff;
  logic [3:0]  ack;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign cnt_wr = bus.wr && (bus.addr == `TMR16_A_CNT_L);

  // interrupt vector acknowledge: one-hot per flag, via its own write address
  assign ack = (bus.wr && bus.addr == `TMR16_A_ACK) ? bus.wdata[3:0] : 4'h0;

  assign src    = tmr16_pkg::tmr16_src_t'(timer_control_b_ff[`TMR16_CB_CS_LSB +: 3]);
  assign topsel = tmr16_pkg::tmr16_topsel_t'(timer_control_b_ff[`TMR16_CB_WGM_LSB +: 3]);
  assign pwm_mode = timer_control_a_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  tmr16_tick tmr16_tick_inst (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .src           (src),
    .ext_clock_pin (ext_clock_pin),
    .timer_tick    (timer_tick)
  );

  tmr16_capin #(
    .NC_LEN (`TMR16_NC_LEN)
  ) tmr16_capin_inst (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .sel_comp          (timer_control_a_ff[1]),
    .noise_cancel      (timer_control_b_ff[`TMR16_CB_NCANCEL]),
    .rise_edge         (timer_control_b_ff[`TMR16_CB_EDGE]),
    .capture_pin       (capture_pin),
    .comparator_output (comparator_output),
    .cap_event         (cap_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control registers, plain byte access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_a_ff <= `TMR16_RST_BYTE;
      timer_control_b_ff <= `TMR16_RST_BYTE;
    end else if (bus.wr && bus.addr == `TMR16_A_CTRL_A) begin
      timer_control_a_ff <= bus.wdata; // R6
    end else if (bus.wr && bus.addr == `TMR16_A_CTRL_B) begin
      timer_control_b_ff <= bus.wdata; // R6
    end
  end

  // shared high-byte holder
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= `TMR16_RST_BYTE;
    end else if (bus.wr && (bus.addr == `TMR16_A_CNT_H || bus.addr == `TMR16_A_CMPA_H ||
                            bus.addr == `TMR16_A_CMPB_H || bus.addr == `TMR16_A_CAP_H)) begin
      hold_ff <= bus.wdata; // R1
    end else if (bus.rd && bus.addr == `TMR16_A_CNT_L) begin
      hold_ff <= count_value_ff[15:8]; // R3
    end else if (bus.rd && bus.addr == `TMR16_A_CAP_L) begin
      hold_ff <= capture_value_ff[15:8]; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (topsel)
      tmr16_pkg::TMR16_TOP_F8:   top_val = `TMR16_TOP_8; // R12
      tmr16_pkg::TMR16_TOP_F9:   top_val = `TMR16_TOP_9;
      tmr16_pkg::TMR16_TOP_F10:  top_val = `TMR16_TOP_10;
      tmr16_pkg::TMR16_TOP_CMPA: top_val = compare_a_value_ff; // R13
      tmr16_pkg::TMR16_TOP_CAP:  top_val = capture_value_ff; // R14
      default:                   top_val = `TMR16_MAX; // R15
    endcase
  end

  assign at_top    = (count_value_ff == top_val);
  assign at_bottom = (count_value_ff == `TMR16_BOTTOM); // R15
  assign match_a   = (count_value_ff == compare_a_value_ff); // R8
  assign match_b   = (count_value_ff == compare_b_value_ff); // R8

  // up-counting wraps at top; pwm mode counts up and down (phase correct)
  always_comb begin
    nxt_count = count_value_ff;
    if (!pwm_mode) begin
      nxt_count = at_top ? `TMR16_BOTTOM : count_value_ff + 16'h0001;
    end else if (up_ff) begin
      nxt_count = at_top ? count_value_ff - 16'h0001 : count_value_ff + 16'h0001;
    end else begin
      nxt_count = at_bottom ? count_value_ff + 16'h0001 : count_value_ff - 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_value_ff <= `TMR16_BOTTOM;
    end else if (cnt_wr) begin
      count_value_ff <= {hold_ff, bus.wdata}; // R2 R17
    end else if (timer_tick) begin
      count_value_ff <= nxt_count; // R7
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      up_ff <= 1'b1;
    end else if (!pwm_mode) begin
      up_ff <= 1'b1;
    end else if (timer_tick && !cnt_wr) begin
      if (at_top) begin
        up_ff <= 1'b0;
      end else if (at_bottom) begin
        up_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare values: cpu writes the buffer, active copy loads at top (pwm)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmpa_buf_ff <= `TMR16_BOTTOM;
      cmpb_buf_ff <= `TMR16_BOTTOM;
    end else if (bus.wr && bus.addr == `TMR16_A_CMPA_L) begin
      cmpa_buf_ff <= {hold_ff, bus.wdata}; // R2
    end else if (bus.wr && bus.addr == `TMR16_A_CMPB_L) begin
      cmpb_buf_ff <= {hold_ff, bus.wdata}; // R2
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_value_ff <= `TMR16_BOTTOM;
      compare_b_value_ff <= `TMR16_BOTTOM;
    end else if (!pwm_mode || (timer_tick && at_top)) begin
      compare_a_value_ff <= cmpa_buf_ff; // R13
      compare_b_value_ff <= cmpb_buf_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capture_value_ff <= `TMR16_BOTTOM;
    end else if (bus.wr && bus.addr == `TMR16_A_CAP_L) begin
      capture_value_ff <= {hold_ff, bus.wdata}; // R2
    end else if (cap_event && topsel != tmr16_pkg::TMR16_TOP_CAP) begin
      capture_value_ff <= count_value_ff; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveforms: toggle on match outside pwm, set/clear on match in pwm except wave a, held low in pwm with compare-a top
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wave_a_ff <= 1'b0;
      wave_b_ff <= 1'b0;
    end else if (timer_tick) begin
      if (topsel == tmr16_pkg::TMR16_TOP_CMPA && pwm_mode) begin
        wave_a_ff <= 1'b0; // R13
      end else if (match_a) begin
        wave_a_ff <= pwm_mode ? up_ff : ~wave_a_ff; // R9
      end
      if (match_b) begin
        wave_b_ff <= pwm_mode ? up_ff : ~wave_b_ff; // R9
      end
    end
  end

  assign wave_out_a = wave_a_ff;
  assign wave_out_b = wave_b_ff;

  ////////////////////////////////////////////////////////////////////////////
  assign set_ev.ovf  = timer_tick && !cnt_wr && (pwm_mode ? at_bottom : at_top);
  assign set_ev.cmpa = timer_tick && match_a; // R8
  assign set_ev.cmpb = timer_tick && match_b; // R8
  assign set_ev.cap  = cap_event && topsel != tmr16_pkg::TMR16_TOP_CAP; // R18
  assign clr_wr = (bus.wr && bus.addr == `TMR16_A_FLAG) ? bus.wdata[3:0] : 4'h0;

  // set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= set_ev | (flag_ff & ~(clr_wr | ack)); // R16 R19
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= '0;
    end else if (bus.wr && bus.addr == `TMR16_A_MASK) begin
      mask_ff <= bus.wdata[3:0]; // R16
    end
  end

  assign irq = |(flag_ff & mask_ff); // R16

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_rdata = 8'h00;
    if (bus.addr == `TMR16_A_CTRL_A) begin
      nxt_rdata = timer_control_a_ff;
    end else if (bus.addr == `TMR16_A_CTRL_B) begin
      nxt_rdata = timer_control_b_ff;
    end else if (bus.addr == `TMR16_A_CNT_L) begin
      nxt_rdata = count_value_ff[7:0];
    end else if (bus.addr == `TMR16_A_CNT_H || bus.addr == `TMR16_A_CAP_H) begin
      nxt_rdata = hold_ff; // R5
    end else if (bus.addr == `TMR16_A_CMPA_L) begin
      nxt_rdata = compare_a_value_ff[7:0]; // R4
    end else if (bus.addr == `TMR16_A_CMPA_H) begin
      nxt_rdata = compare_a_value_ff[15:8]; // R4
    end else if (bus.addr == `TMR16_A_CMPB_L) begin
      nxt_rdata = compare_b_value_ff[7:0]; // R4
    end else if (bus.addr == `TMR16_A_CMPB_H) begin
      nxt_rdata = compare_b_value_ff[15:8]; // R4
    end else if (bus.addr == `TMR16_A_CAP_L) begin
      nxt_rdata = capture_value_ff[7:0];
    end else if (bus.addr == `TMR16_A_FLAG) begin
      nxt_rdata = {4'h0, flag_ff};
    end else if (bus.addr == `TMR16_A_MASK) begin
      nxt_rdata = {4'h0, mask_ff};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_cnt_write: assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_wr |=> count_value_ff == {$past(hold_ff), $past(bus.wdata)}) // R2 R17
    else $error("counter low write did not load both bytes");

  a_hold_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == `TMR16_A_CNT_L) |=> hold_ff == $past(count_value_ff[15:8])) // R3
    else $error("holder not loaded on low read");

  a_cmp_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == `TMR16_A_CMPA_H) |=> $stable(hold_ff)
    && reg_rdata == $past(compare_a_value_ff[15:8])) // R4
    else $error("compare read touched holder");

  a_ctrl_wr: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus.wr && bus.addr == `TMR16_A_CTRL_B) |=> timer_control_b_ff == $past(bus.wdata)) // R6
    else $error("control write lost");

  a_stop_cnt: assert property (@(posedge mclk) disable iff (!rst_n)
    (src == tmr16_pkg::TMR16_SRC_STOP && !cnt_wr) ##1 !$past(cnt_wr)
    |-> $stable(count_value_ff)) // R7
    else $error("counter moved with no source");

  a_cap_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    set_ev.cap |=> flag_ff.cap && capture_value_ff == $past(count_value_ff)) // R10 R18
    else $error("capture flag and value not together");

  a_cmp_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    set_ev.cmpa |=> flag_ff.cmpa) // R8
    else $error("compare a flag missed");

  a_flag_clr: assert property (@(posedge mclk) disable iff (!rst_n)
    (clr_wr[`TMR16_B_OVF] && !set_ev.ovf) |=> !flag_ff.ovf) // R19
    else $error("overflow flag not cleared");

  a_irq_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    irq == |(flag_ff & mask_ff)) // R16
    else $error("irq does not follow masked flags");

endmodule

// [bench/tmr16_cpu_model.sv]
`timescale 1ns/1ps
`include "tmr16_cfg.svh"

module tmr16_cpu_model (
  // clock
  input  wire logic             mclk,
  // register port
  output tmr16_pkg::tmr16_bus_t bus,
  input  wire logic [7:0]       reg_rdata
);

  initial begin
    bus = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk);
    bus.wr    <= 1'b0;
    bus.wdata <= ~d;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr16(input logic [7:0] a_lo, input logic [15:0] v);
    wr8(a_lo + 8'h01, v[15:8]);
    wr8(a_lo, v[7:0]);
  endtask

  task automatic rd16(input logic [7:0] a_lo, output logic [15:0] v);
    rd8(a_lo, v[7:0]);
    rd8(a_lo + 8'h01, v[15:8]);
  endtask

  // models the core entering the interrupt vectors
  task automatic vector_ack(input logic [3:0] bits);
    wr8(`TMR16_A_ACK, {4'h0, bits});
  endtask

endmodule

// [bench/test_tmr16_top.sv]
`timescale 1ns/1ps
`include "tmr16_cfg.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end

module test_tmr16_top;

  logic                  mclk;
  logic                  reset_n;
  logic                  ext_clock_pin;
  logic                  capture_pin;
  logic                  comparator_output;
  logic            [7:0] reg_rdata;
  logic                  wave_out_a;
  logic                  wave_out_b;
  logic                  irq;
  tmr16_pkg::tmr16_bus_t bus;
  int                    bad_count;
  int                    n_tests;
  logic            [7:0] b;
  logic           [15:0] w;

  tmr16_cpu_model tmr16_cpu_model_inst (
    .mclk      (mclk),
    .bus       (bus),
    .reg_rdata (reg_rdata)
  );

  tmr16_top tmr16_top_inst (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .reg_addr          (bus.addr),
    .reg_wdata         (bus.wdata),
    .reg_wr            (bus.wr),
    .reg_rd            (bus.rd),
    .reg_rdata         (reg_rdata),
    .ext_clock_pin     (ext_clock_pin),
    .capture_pin       (capture_pin),
    .comparator_output (comparator_output),
    .wave_out_a        (wave_out_a),
    .wave_out_b        (wave_out_b),
    .irq               (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // holder sharing with counter stopped
  task automatic t_holder();
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h00);
    tmr16_cpu_model_inst.wr16(`TMR16_A_CNT_L, 16'h01FF);
    tmr16_cpu_model_inst.rd16(`TMR16_A_CNT_L, w);
    `CHK(w, 16'h01FF)
    tmr16_cpu_model_inst.wr8(`TMR16_A_CNT_H, 8'hAB);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CMPB_L, 8'h34);
    tmr16_cpu_model_inst.wr16(`TMR16_A_CMPA_L, 16'h0005);
    tmr16_cpu_model_inst.rd8(`TMR16_A_CNT_L, b);
    `CHK(b, 8'hFF)
    tmr16_cpu_model_inst.rd8(`TMR16_A_CMPB_H, b);
    `CHK(b, 8'hAB)
    tmr16_cpu_model_inst.rd8(`TMR16_A_CMPB_L, b);
    `CHK(b, 8'h34)
    tmr16_cpu_model_inst.rd8(`TMR16_A_CMPA_H, b);
    `CHK(b, 8'h00)
    tmr16_cpu_model_inst.rd8(`TMR16_A_CNT_H, b);
    `CHK(b, 8'h01)
    tmr16_cpu_model_inst.rd8(8'h0D, b);
    `CHK(b, 8'h00)
  endtask

  // direct byte control access and external edges
  task automatic t_ext_clock();
    tmr16_cpu_model_inst.wr16(`TMR16_A_CNT_L, 16'h0000);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h07);
    tmr16_cpu_model_inst.rd8(`TMR16_A_CTRL_B, b);
    `CHK(b, 8'h07)
    repeat (3) begin
      @(posedge mclk) ext_clock_pin <= 1'b1;
      cycles(4);
      ext_clock_pin <= 1'b0;
      cycles(4);
    end
    cycles(4);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h00);
    cycles(4);
    tmr16_cpu_model_inst.rd16(`TMR16_A_CNT_L, w);
    `CHK(w, 16'h0003)
  endtask

  // capture from pin, filtered and comparator source
  task automatic t_capture();
    tmr16_cpu_model_inst.wr16(`TMR16_A_CNT_L, 16'h1234);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h40);
    @(posedge mclk) capture_pin <= 1'b1;
    cycles(10);
    tmr16_cpu_model_inst.rd16(`TMR16_A_CAP_L, w);
    `CHK(w, 16'h1234)
    tmr16_cpu_model_inst.rd8(`TMR16_A_FLAG, b);
    `CHK(b, 8'h08)
    tmr16_cpu_model_inst.wr8(`TMR16_A_FLAG, 8'h08);
    tmr16_cpu_model_inst.rd8(`TMR16_A_FLAG, b);
    `CHK(b, 8'h00)
    tmr16_cpu_model_inst.wr16(`TMR16_A_CNT_L, 16'h5678);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'hC0);
    @(posedge mclk) capture_pin <= 1'b0;
    cycles(10);
    capture_pin <= 1'b1;
    cycles(2);
    capture_pin <= 1'b0;
    cycles(10);
    tmr16_cpu_model_inst.rd8(`TMR16_A_FLAG, b);
    `CHK(b, 8'h00)
    @(posedge mclk) capture_pin <= 1'b1;
    cycles(12);
    tmr16_cpu_model_inst.rd16(`TMR16_A_CAP_L, w);
    `CHK(w, 16'h5678)
    tmr16_cpu_model_inst.wr16(`TMR16_A_CNT_L, 16'h9ABC);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_A, 8'h02);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h40);
    @(posedge mclk) comparator_output <= 1'b1;
    cycles(10);
    tmr16_cpu_model_inst.rd16(`TMR16_A_CAP_L, w);
    `CHK(w, 16'h9ABC)
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_A, 8'h00);
    tmr16_cpu_model_inst.wr8(`TMR16_A_FLAG, 8'h0F);
  endtask

  // compare match, wave toggle, fixed top, mask and clears
  task automatic t_compare();
    tmr16_cpu_model_inst.wr16(`TMR16_A_CNT_L, 16'h0000);
    tmr16_cpu_model_inst.wr16(`TMR16_A_CMPB_L, 16'h0010);
    tmr16_cpu_model_inst.wr8(`TMR16_A_MASK, 8'h00);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h09);
    cycles(100);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h08);
    `CHK(wave_out_a, 1'b1)
    `CHK(wave_out_b, 1'b1)
    `CHK(irq, 1'b0)
    tmr16_cpu_model_inst.rd8(`TMR16_A_FLAG, b);
    `CHK(b & 8'h0E, 8'h06)
    tmr16_cpu_model_inst.wr8(`TMR16_A_MASK, 8'h02);
    cycles(2);
    `CHK(irq, 1'b1)
    tmr16_cpu_model_inst.vector_ack(4'h2);
    cycles(2);
    `CHK(irq, 1'b0)
    tmr16_cpu_model_inst.rd8(`TMR16_A_FLAG, b);
    `CHK(b & 8'h02, 8'h00)
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h09);
    cycles(400);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h08);
    `CHK(irq, 1'b1)
    `CHK(wave_out_b, 1'b0)
    tmr16_cpu_model_inst.rd8(`TMR16_A_FLAG, b);
    `CHK(b, 8'h07)
    tmr16_cpu_model_inst.rd16(`TMR16_A_CNT_L, w);
    `CHK(w[15:8], 8'h00)
    tmr16_cpu_model_inst.wr8(`TMR16_A_FLAG, 8'h0F);
    cycles(2);
    `CHK(irq, 1'b0)
  endtask

  // cpu write wins over counting
  task automatic t_write_priority();
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h01);
    tmr16_cpu_model_inst.wr16(`TMR16_A_CNT_L, 16'h0300);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h00);
    tmr16_cpu_model_inst.rd16(`TMR16_A_CNT_L, w);
    `CHK(w[15:8], 8'h03)
    `CHK(w[7:0] < 8'h10, 1'b1)
  endtask

  // phase correct pwm with compare-a as top
  task automatic t_pwm();
    tmr16_cpu_model_inst.wr16(`TMR16_A_CNT_L, 16'h0000);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_A, 8'h01);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h21);
    cycles(30);
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_B, 8'h20);
    `CHK(wave_out_a, 1'b0)
    tmr16_cpu_model_inst.rd16(`TMR16_A_CNT_L, w);
    `CHK(w <= 16'h0005, 1'b1)
    tmr16_cpu_model_inst.rd8(`TMR16_A_FLAG, b);
    `CHK(b & 8'h01, 8'h01)
    tmr16_cpu_model_inst.wr8(`TMR16_A_CTRL_A, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count         = 0;
    n_tests           = 0;
    reset_n           = 1'b0;
    ext_clock_pin     = 1'b0;
    capture_pin       = 1'b0;
    comparator_output = 1'b0;
    cycles(5);
    reset_n <= 1'b1;
    cycles(4);
    `CHK(irq, 1'b0)
    t_holder();
    t_ext_clock();
    t_capture();
    t_compare();
    t_write_priority();
    t_pwm();
    tally_and_finish();
  end

  // watchdog
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

endmodule
